// >>> bench/host_sink.sv
/*
  Host side model: takes the framer's byte stream and keeps every byte taken
  in a queue that the bench parses and judges.
  Assumes the framer's clock; slow selects a stalling ready pattern.
*/
`timescale 1ns/1ps
module host_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] rx[$];
  logic [2:0] phase;

  // A slow host takes one byte in eight, so the FIFO fills and must hold.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
      out_ready <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      out_ready <= !slow || (phase == 3'h6);
      if (out_valid && out_ready) begin
        rx.push_back(out_data);
      end
    end
  end
endmodule

// >>> bench/tb.sv
/*
  Self-checking bench for the status response framer.
  Assumes the host model keeps the taken bytes in its queue rx.
*/
`timescale 1ns/1ps
module tb;
  import framer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic [EV_N-1:0] events = '0;
  logic stack_err = 1'b0;
  logic [6:0] stack_code = 7'h00;
  logic txs_valid = 1'b0, txs_broadcast = 1'b0, cmd_valid = 1'b0, cmd_query = 1'b0;
  logic txs_ready, cmd_ready, out_valid, out_ready;
  logic [7:0] txs_frame_id = 8'h00, txs_retry = 8'h00, txs_delivery = 8'h00;
  logic [7:0] txs_discovery = 8'h00, cmd_frame_id = 8'h00, cmd_status = 8'h00, out_data;
  logic [15:0] txs_dest = 16'h0000, txs_found = 16'h0000;
  logic [15:0] cmd_name = 16'h0000, cmd_value = 16'h0000;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] ev_exp [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h11, 8'h32,
    8'h33, 8'h34, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h42, 8'h43, 8'h44, 8'h45};

  always #2 clk = ~clk;

  status_response_framer dut (.clk(clk), .rst_n(rst_n), .events(events),
    .stack_err(stack_err), .stack_code(stack_code), .txs_valid(txs_valid),
    .txs_ready(txs_ready), .txs_frame_id(txs_frame_id), .txs_dest(txs_dest),
    .txs_found(txs_found), .txs_retry(txs_retry), .txs_delivery(txs_delivery),
    .txs_discovery(txs_discovery), .txs_broadcast(txs_broadcast), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_frame_id(cmd_frame_id), .cmd_name(cmd_name),
    .cmd_status(cmd_status), .cmd_query(cmd_query), .cmd_value(cmd_value),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

  host_sink host (.clk(clk), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic give_up(input string what);
    $display("BAD %s expected done seen timeout", what);
    n_fail++;
    stop_test();
  endtask

  // Parses one frame off the host queue; the checksum is worked out here.
  task automatic expect_frame(input string what, input logic [7:0] p[$]);
    int k;
    logic [7:0] sum;
    k = 0;
    sum = 8'h00;
    while (host.rx.size() < p.size() + 4 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k == 400) give_up(what);
    check({what, " start"}, 8'h7e, host.rx.pop_front());
    check({what, " len_hi"}, 8'h00, host.rx.pop_front());
    check({what, " len_lo"}, 8'(p.size()), host.rx.pop_front());
    foreach (p[i]) begin
      check({what, " body"}, p[i], host.rx.pop_front());
      sum = sum + p[i];
    end
    check({what, " checksum"}, 8'hff - sum, host.rx.pop_front());
  endtask

  task automatic expect_none(input string what);
    repeat (40) @(posedge clk);
    check(what, 8'h00, 8'(host.rx.size()));
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    #1 events = EV_N'(1) << i;
    @(posedge clk);
    #1 events = '0;
  endtask

  task automatic send_txs(input logic [7:0] id, input logic [15:0] dest, found,
      input logic [7:0] retry, deliv, input logic bc);
    int k;
    k = 0;
    @(posedge clk);
    #1 txs_frame_id = id;
    txs_dest = dest;
    txs_found = found;
    txs_retry = retry;
    txs_delivery = deliv;
    txs_discovery = retry ^ 8'h01;
    txs_broadcast = bc;
    txs_valid = 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (!txs_ready && k < 400);
    if (k == 400) give_up("txs_ready");
    #1 txs_valid = 1'b0;
    check("txs_ready", {7'h00, id == 8'h00}, {7'h00, txs_ready});
  endtask

  task automatic send_cmd(input logic [7:0] id, input logic [15:0] name, value,
      input logic query);
    int k;
    k = 0;
    @(posedge clk);
    #1 cmd_frame_id = id;
    cmd_name = name;
    cmd_value = value;
    cmd_query = query;
    cmd_valid = 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (!cmd_ready && k < 400);
    if (k == 400) give_up("cmd_ready");
    #1 cmd_valid = 1'b0;
    check("cmd_ready", {7'h00, id == 8'h00}, {7'h00, cmd_ready});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_events();
    expect_frame("boot", '{8'h8a, 8'h00});
    for (int i = 0; i < EV_N; i++) begin
      if (i != 16) begin
        pulse(i);
        expect_frame("event", '{8'h8a, ev_exp[i]});
      end
    end
    $display("test events done");
  endtask

  task automatic test_watchdog();
    pulse(16);
    pulse(16);
    expect_none("wdog early");
    pulse(16);
    expect_frame("wdog", '{8'h8a, 8'h42});
    $display("test watchdog done");
  endtask

  task automatic test_stack();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      #1 stack_code = (c == 0) ? 7'h00 : 7'h7f;
      stack_err = 1'b1;
      @(posedge clk);
      #1 stack_err = 1'b0;
      expect_frame("stack", '{8'h8a, {1'b1, stack_code}});
    end
    $display("test stack done");
  endtask

  task automatic test_txs();
    send_txs(8'h11, 16'hfffe, 16'h1234, 8'h02, 8'h00, 1'b0);
    expect_frame("txs found", '{8'h8b, 8'h11, 8'h12, 8'h34, 8'h02, 8'h00, 8'h03});
    send_txs(8'h00, 16'h5678, 16'h0000, 8'h00, 8'h00, 1'b0);
    expect_none("txs id zero");
    send_txs(8'h12, 16'hffff, 16'h0000, 8'h00, 8'h26, 1'b1);
    expect_frame("txs bcast", '{8'h8b, 8'h12, 8'hff, 8'hff, 8'h00, 8'h00, 8'h01});
    send_txs(8'h13, 16'h5678, 16'h0000, 8'h03, 8'h21, 1'b0);
    expect_frame("txs fail", '{8'h8b, 8'h13, 8'hff, 8'hfd, 8'h03, 8'h21, 8'h02});
    $display("test txs done");
  endtask

  task automatic test_cmd();
    send_cmd(8'h01, 16'h4e49, 16'h0000, 1'b0);
    expect_frame("cmd set", '{8'h88, 8'h01, 8'h4e, 8'h49, 8'h00});
    send_cmd(8'h00, 16'h4e49, 16'h0000, 1'b0);
    expect_none("cmd id zero");
    #1 slow = 1'b1;
    send_cmd(8'h17, 16'h5450, 16'hfffe, 1'b1);
    send_txs(8'h14, 16'h5678, 16'h0000, 8'h00, 8'h00, 1'b0);
    expect_frame("cmd query", '{8'h88, 8'h17, 8'h54, 8'h50, 8'h00, 8'hff, 8'hfe});
    expect_frame("txs stall", '{8'h8b, 8'h14, 8'h56, 8'h78, 8'h00, 8'h00, 8'h01});
    #1 slow = 1'b0;
    $display("test cmd done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    test_events();
    test_watchdog();
    test_stack();
    test_txs();
    test_cmd();
    stop_test();
  end
endmodule

// >>> rtl/byte_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign in_ready = st.count != CW'(D);
  assign out_valid = st.count != '0;
  assign out_data = st.mem[st.rptr];

  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wptr] = in_data;
      next_st.wptr = (st.wptr == PW'(D - 1)) ? '0 : PW'(st.wptr + 1'b1);
    end
    if (pop) begin
      next_st.rptr = (st.rptr == PW'(D - 1)) ? '0 : PW'(st.rptr + 1'b1);
    end
    if (push && !pop) begin
      next_st.count = CW'(st.count + 1'b1);
    end else if (pop && !push) begin
      next_st.count = CW'(st.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> rtl/framer_pkg.sv
/*
  Shared constants for the status response framer: frame bytes, frame types,
  payload lengths, modem status codes and FIFO geometry.
  Assumes it is compiled before every module that imports it.
*/
package framer_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] SOF = 8'h7e;
  localparam logic [7:0] LEN_HI = 8'h00;
  localparam logic [7:0] CKS_BASE = 8'hff;
  localparam logic [3:0] HDR_BYTES = 4'h3;
  localparam logic [7:0] TYPE_MODEM = 8'h8a;
  localparam logic [7:0] TYPE_TXS = 8'h8b;
  localparam logic [7:0] TYPE_CMD = 8'h88;
  localparam logic [3:0] LEN_MODEM = 4'h2;
  localparam logic [3:0] LEN_TXS = 4'h7;
  localparam logic [3:0] LEN_SET = 4'h5;
  localparam logic [3:0] LEN_QUERY = 4'h7;
  localparam logic [7:0] NO_FRAME_ID = 8'h00;

  // ----------------------------------------------------------------------
  // Transmit status fields
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_DISCOVER = 16'hfffe;
  localparam logic [15:0] ADDR_UNKNOWN = 16'hfffd;
  localparam logic [7:0] DELIV_OK = 8'h00;

  // ----------------------------------------------------------------------
  // Modem status events, index 0 has the highest priority
  // ----------------------------------------------------------------------
  localparam int EV_N = 20;
  localparam int EV_POWER = 0;
  localparam int EV_NET_WDOG = 16;
  localparam logic [EV_N-1:0] PEND_RESET = 20'h00001;
  localparam logic [1:0] WDOG_LIMIT = 2'h3;
  localparam logic [7:0] STACK_ERR_BASE = 8'h80;
  localparam logic [EV_N-1:0][7:0] EV_CODE = {
    8'h45, 8'h44, 8'h43, 8'h42, 8'h40, 8'h3f, 8'h3e, 8'h3d, 8'h3c, 8'h3b,
    8'h34, 8'h33, 8'h32, 8'h11, 8'h07, 8'h06, 8'h03, 8'h02, 8'h01, 8'h00};

  // ----------------------------------------------------------------------
  // Output buffering and control
  // ----------------------------------------------------------------------
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;

  typedef enum logic [0:0] {IDLE, SEND} fsm_t;

endpackage

// >>> rtl/status_response_framer.sv
/*
  Status response framer: builds modem status, transmit status and local
  command response frames and streams them byte by byte through a FIFO.
  Assumes request inputs come from logic on the same clock and that the
  sink honours out_valid/out_ready.
*/
// Overview of operation
// R01: Modem status frame is SOF, 16-bit length, type 0x8A, one status byte.
// R02: Last byte is 0xFF minus the low sum of bytes from offset 3.
// R03: Status 0x00 reset, 0x01 watchdog, 0x02 joined, 0x03 left, 0x06 coordinator.
// R04: Secure session established 0x3B, ended 0x3C, authentication failed 0x3D.
// R05: Join window open 0x43, closed 0x44, key rotation started 0x45.
// R06: Status codes 0x80 to 0xFF signal a stack error.
// R07: PAN conflict ignored 0x3E, coordinator changed 0x3F, router changed 0x40.
// R08: Status 0x42 after the network watchdog expires three times.
// R09: After power up a modem status frame with status 0x00 is sent.
// R10: A finished network transmission yields a type 0x8B transmit status frame.
// R11: No transmit status frame when the request frame identifier is zero.
// R12: Requests to 0xFFFE report the discovered address; host reuses it.
// R13: Broadcasts always report delivery status 0x00.
// R14: Parameter set answers type 0x88, matching identifier, status, no data.
// R15: Parameter query answers with matching identifier and the current value.
// R16: Short-range link connect 0x32, disconnect 0x33, no secure session 0x34.
// R17: Security key updated 0x07, configuration changed during join 0x11.
// R18: Transmit status holds id, address, retries, delivery, discovery at 4..9.
// R19: Host pairs responses with requests through the echoed frame identifier.
// R20: Receivers drop frames with bad checksum and resync on next delimiter.
`timescale 1ns/1ps
module status_response_framer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [framer_pkg::EV_N-1:0] events,
  input wire logic stack_err,
  input wire logic [6:0] stack_code,
  input wire logic txs_valid,
  output logic txs_ready,
  input wire logic [7:0] txs_frame_id,
  input wire logic [15:0] txs_dest,
  input wire logic [15:0] txs_found,
  input wire logic [7:0] txs_retry,
  input wire logic [7:0] txs_delivery,
  input wire logic [7:0] txs_discovery,
  input wire logic txs_broadcast,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_frame_id,
  input wire logic [15:0] cmd_name,
  input wire logic [7:0] cmd_status,
  input wire logic cmd_query,
  input wire logic [15:0] cmd_value,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  import framer_pkg::*;

  typedef struct packed {
    fsm_t fsm;
    logic [7:0][7:0] pl;
    logic [3:0] len;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [EV_N-1:0] pend;
    logic stk_pend;
    logic [6:0] stk_code;
    logic [1:0] wdog_cnt;
    logic txs_full;
    logic txs_rdy;
    logic [7:0] txs_id;
    logic [15:0] txs_addr;
    logic [7:0] txs_retry;
    logic [7:0] txs_deliv;
    logic [7:0] txs_disc;
    logic cmd_full;
    logic cmd_rdy;
    logic cmd_q;
    logic [7:0] cmd_id;
    logic [15:0] cmd_name;
    logic [7:0] cmd_st;
    logic [15:0] cmd_val;
    logic out_valid;
    logic [7:0] out_data;
  } framer_state_t;

  localparam framer_state_t RESET_ST = '{fsm: IDLE, pend: PEND_RESET, txs_rdy: 1'b1,
                                         cmd_rdy: 1'b1, default: '0};

  framer_state_t st;
  framer_state_t next_st;
  logic [7:0] cur;
  logic last;
  logic push_valid;
  logic push_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic [EV_N-1:0] ev_set;
  logic [EV_N-1:0] ev_clr;
  logic [4:0] sel;
  logic txs_take;
  logic cmd_take;
  logic txs_fail;
  logic load_cmd;
  logic load_txs;
  logic load_ev;
  logic load_stk;

  assign txs_ready = st.txs_rdy;
  assign cmd_ready = st.cmd_rdy;
  assign out_valid = st.out_valid;
  assign out_data = st.out_data;

  // ----------------------------------------------------------------------
  // Byte buffer
  // ----------------------------------------------------------------------
  // The FIFO lets the frame builder run ahead of a slow sink; when it fills,
  // push_ready drops and the builder holds its byte.
  byte_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(cur),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    ev_set = events;
    ev_clr = '0;
    sel = '0;
    load_cmd = 1'b0;
    load_txs = 1'b0;
    load_ev = 1'b0;
    load_stk = 1'b0;
    push_valid = 1'b0;

    // Frame byte at the current position.
    last = st.idx == st.len + HDR_BYTES;
    if (st.idx == 4'h0) begin
      cur = SOF; // R01
    end else if (st.idx == 4'h1) begin
      cur = LEN_HI;
    end else if (st.idx == 4'h2) begin
      cur = {4'h0, st.len};
    end else if (last) begin
      cur = CKS_BASE - st.sum; // R02 R20
    end else begin
      cur = st.pl[3'(st.idx - HDR_BYTES)];
    end

    // Output register stage so every output port comes from a flip-flop.
    fifo_pop = !st.out_valid || out_ready;
    if (fifo_pop) begin
      next_st.out_valid = fifo_valid;
      next_st.out_data = fifo_data;
    end

    // Transmit completion capture; zero identifiers are swallowed silently.
    txs_take = txs_valid && st.txs_rdy;
    txs_fail = txs_delivery != DELIV_OK && !txs_broadcast;
    if (txs_take && txs_frame_id != NO_FRAME_ID) begin // R11
      next_st.txs_full = 1'b1;
      next_st.txs_id = txs_frame_id;
      next_st.txs_retry = txs_retry;
      next_st.txs_disc = txs_discovery;
      next_st.txs_deliv = txs_broadcast ? DELIV_OK : txs_delivery; // R13
      if (txs_fail) begin
        next_st.txs_addr = ADDR_UNKNOWN; // R18
      end else if (txs_dest == ADDR_DISCOVER) begin
        next_st.txs_addr = txs_found; // R12
      end else begin
        next_st.txs_addr = txs_dest;
      end
    end

    // Local command capture.
    cmd_take = cmd_valid && st.cmd_rdy;
    if (cmd_take && cmd_frame_id != NO_FRAME_ID) begin
      next_st.cmd_full = 1'b1;
      next_st.cmd_id = cmd_frame_id;
      next_st.cmd_name = cmd_name;
      next_st.cmd_st = cmd_status;
      next_st.cmd_q = cmd_query;
      next_st.cmd_val = cmd_value;
    end

    // Only every third network watchdog expiry raises its status event.
    ev_set[EV_NET_WDOG] = 1'b0;
    if (events[EV_NET_WDOG]) begin
      if (st.wdog_cnt == WDOG_LIMIT - 2'h1) begin
        next_st.wdog_cnt = 2'h0;
        ev_set[EV_NET_WDOG] = 1'b1; // R08
      end else begin
        next_st.wdog_cnt = 2'(st.wdog_cnt + 2'h1);
      end
    end

    // Lowest pending index wins.
    for (int i = EV_N - 1; i >= 0; i--) begin
      if (st.pend[i]) begin
        sel = 5'(i);
      end
    end

    case (st.fsm)
      IDLE: begin
        next_st.idx = 4'h0;
        next_st.sum = 8'h00;
        next_st.pl = '0;
        if (st.cmd_full) begin
          load_cmd = 1'b1;
          next_st.cmd_full = 1'b0;
          next_st.pl[0] = TYPE_CMD; // R14
          next_st.pl[1] = st.cmd_id; // R19
          next_st.pl[2] = st.cmd_name[15:8];
          next_st.pl[3] = st.cmd_name[7:0];
          next_st.pl[4] = st.cmd_st;
          next_st.pl[5] = st.cmd_val[15:8]; // R15
          next_st.pl[6] = st.cmd_val[7:0];
          next_st.len = st.cmd_q ? LEN_QUERY : LEN_SET; // R14
          next_st.fsm = SEND;
        end else if (st.txs_full) begin
          load_txs = 1'b1;
          next_st.txs_full = 1'b0;
          next_st.pl[0] = TYPE_TXS; // R10
          next_st.pl[1] = st.txs_id; // R18
          next_st.pl[2] = st.txs_addr[15:8];
          next_st.pl[3] = st.txs_addr[7:0];
          next_st.pl[4] = st.txs_retry;
          next_st.pl[5] = st.txs_deliv;
          next_st.pl[6] = st.txs_disc;
          next_st.len = LEN_TXS;
          next_st.fsm = SEND;
        end else if (|st.pend) begin
          load_ev = 1'b1;
          ev_clr[sel] = 1'b1;
          next_st.pl[0] = TYPE_MODEM; // R01
          next_st.pl[1] = EV_CODE[sel]; // R03 R04 R05 R07 R09 R16 R17
          next_st.len = LEN_MODEM;
          next_st.fsm = SEND;
        end else if (st.stk_pend) begin
          load_stk = 1'b1;
          next_st.stk_pend = 1'b0;
          next_st.pl[0] = TYPE_MODEM;
          next_st.pl[1] = STACK_ERR_BASE | {1'b0, st.stk_code}; // R06
          next_st.len = LEN_MODEM;
          next_st.fsm = SEND;
        end
      end
      SEND: begin
        push_valid = 1'b1;
        if (push_ready) begin
          next_st.idx = 4'(st.idx + 4'h1);
          if (st.idx >= HDR_BYTES && !last) begin
            next_st.sum = 8'(st.sum + cur); // R02
          end
          if (last) begin
            next_st.fsm = IDLE;
          end
        end
      end
      default: begin
        next_st.fsm = IDLE;
      end
    endcase

    // A new event in the cycle its flag is consumed is kept.
    next_st.pend = (st.pend & ~ev_clr) | ev_set;
    if (stack_err) begin
      next_st.stk_pend = 1'b1;
      next_st.stk_code = stack_code;
    end
    next_st.txs_rdy = !next_st.txs_full;
    next_st.cmd_rdy = !next_st.cmd_full;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RESET_ST; // R09
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sof;
    st.fsm == SEND && $past(st.fsm) == IDLE |-> st.idx == 4'h0 && cur == SOF;
  endproperty
  a_sof: assert property (p_sof) else $error("frame does not open with delimiter"); // R01

  property p_sum;
    push_valid && push_ready && st.idx >= HDR_BYTES && !last
      |=> st.sum == 8'($past(st.sum) + $past(cur));
  endproperty
  a_sum: assert property (p_sum) else $error("checksum sum not accumulated"); // R02

  property p_zero_id;
    txs_take && txs_frame_id == NO_FRAME_ID && !st.txs_full |=> !st.txs_full;
  endproperty
  a_zero_id: assert property (p_zero_id) else $error("zero id transmit status kept"); // R11

  property p_bcast;
    txs_take && txs_frame_id != NO_FRAME_ID && txs_broadcast |=> st.txs_deliv == DELIV_OK;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast delivery not success"); // R13

  property p_discover;
    txs_take && txs_frame_id != NO_FRAME_ID && !txs_fail && txs_dest == ADDR_DISCOVER
      |=> st.txs_addr == $past(txs_found);
  endproperty
  a_discover: assert property (p_discover) else $error("discovered address lost"); // R12

  property p_set;
    load_cmd && !st.cmd_q |=> st.len == LEN_SET && st.pl[0] == TYPE_CMD && st.fsm == SEND;
  endproperty
  a_set: assert property (p_set) else $error("set response has wrong length"); // R14

  property p_query;
    load_cmd && st.cmd_q |=> st.len == LEN_QUERY && st.pl[6] == $past(st.cmd_val[7:0]);
  endproperty
  a_query: assert property (p_query) else $error("query response lacks value"); // R15

  property p_wdog;
    events[EV_NET_WDOG] && st.wdog_cnt == 2'h2 |=> st.pend[EV_NET_WDOG] && st.wdog_cnt == 2'h0;
  endproperty
  a_wdog: assert property (p_wdog) else $error("third watchdog expiry not raised"); // R08

  property p_wdog_early;
    events[EV_NET_WDOG] && st.wdog_cnt != 2'h2 && !st.pend[EV_NET_WDOG]
      |=> !st.pend[EV_NET_WDOG];
  endproperty
  a_wdog_early: assert property (p_wdog_early) else $error("watchdog event raised early"); // R08

  property p_txs;
    load_txs |=> st.pl[0] == TYPE_TXS && st.pl[1] == $past(st.txs_id) && st.len == LEN_TXS;
  endproperty
  a_txs: assert property (p_txs) else $error("transmit status frame malformed"); // R10

  property p_stack;
    load_stk |=> st.pl[1][7] && st.len == LEN_MODEM;
  endproperty
  a_stack: assert property (p_stack) else $error("stack error code below range"); // R06

  c_boot: cover property (load_ev && sel == 5'(EV_POWER));
  c_query: cover property (load_cmd && st.cmd_q);
  c_full: cover property (push_valid && !push_ready);
  c_txs: cover property (load_txs ##[1:20] st.fsm == IDLE);
endmodule
